// ### rtl/vesms_pkg.sv
package vesms_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GBASE = 8'h04;
	localparam logic [7:0] REG_MBASE = 8'h08;
	localparam logic [7:0] REG_MCOUNT = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_FAILIDX = 8'h14;
	// control fields
	localparam int CTRL_VNMI = 0;
	localparam int CTRL_SAVE_TMR = 1;
	localparam int CTRL_SLT_EN = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ABORT = 2;
	localparam int ST_CAUSE = 4;
	// fail causes
	localparam logic [2:0] F_NONE = 3'h0;
	localparam logic [2:0] F_APIC = 3'h1;
	localparam logic [2:0] F_SMM = 3'h2;
	localparam logic [2:0] F_MODEL = 3'h3;
	localparam logic [2:0] F_HIGH = 3'h4;
	localparam logic [2:0] F_GP = 3'h5;
	// save-area field offsets from the guest base
	localparam logic [31:0] G_ACT = 32'h0000_0000;
	localparam logic [31:0] G_INTR = 32'h0000_0008;
	localparam logic [31:0] G_PDBG = 32'h0000_0010;
	localparam logic [31:0] G_TMR = 32'h0000_0018;
	localparam logic [31:0] G_PDP = 32'h0000_0020;
	// msr-store entry layout
	localparam logic [31:0] ENT_SIZE = 32'h0000_0010;
	localparam logic [31:0] ENT_DATA = 32'h0000_0008;
	localparam logic [23:0] APIC_RANGE = 24'h00_0008;
	// interruptibility bits
	localparam int INTR_SMI = 2;
	localparam int INTR_NMI = 3;
	// pending-debug bits
	localparam int PD_EBP = 12;
	localparam int PD_BS = 14;
	localparam logic [63:0] PD_MASK = 64'h0000_0000_0000_500f;
	localparam logic [63:0] PDP_UNDEF = 64'h0000_0000_0000_0e00;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/vesms_top.sv
`timescale 1ns/100ps
// How it works
// RQ1: save activity state before the exit
// RQ2: interruptibility bit 2 zero unless ending in smm
// RQ3: bit 3 shows virtual blocking when enabled
// RQ4: pending-debug zero except listed exit kinds
// RQ5: bits 3:0 may show any matched breakpoint
// RQ6: kept field shows pending debug causes
// RQ7: right after entry, entry value may stand
// RQ8: bit 12 from enabled hits or undelivered entry
// RQ9: bit 14 from single-step and branch trap
// RQ10: stack-load case bit 14 clear if unsafe
// RQ11: reserved pending-debug bits written zero
// RQ12: timer saved per control, zero on expiry
// RQ13: save four pointer entries when translating
// RQ14: otherwise pointer entries left undefined
// RQ15: msr store only after guest state saved
// RQ16: entries in order, msr value into 127:64
// RQ17: index 31:8 equal 000008h fails
// RQ18: smm-only msr fails outside smm
// RQ19: model-barred msr may fail
// RQ20: nonzero entry bits 63:32 fail
// RQ21: read raising protection fault fails
// RQ22: any failed entry raises exit abort
// RQ23: after abort, no entries and no host load
module vesms_top #(
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic exit_start,
	input wire logic exit_to_smm,
	input wire logic [31:0] activity_state,
	input wire logic [31:0] intr_state,
	input wire logic vnmi_blocked,
	input wire logic exit_init,
	input wire logic exit_mce,
	input wire logic exit_smi,
	input wire logic exit_tpl,
	input wire logic exit_veoi,
	input wire logic exit_apicw,
	input wire logic exit_mtf,
	input wire logic exit_dbg,
	input wire logic ss_load_block,
	input wire logic just_entered,
	input wire logic [63:0] entry_pdbg,
	input wire logic [3:0] bp_matched,
	input wire logic enabled_bp_hit,
	input wire logic entry_pending_live,
	input wire logic single_step_flag,
	input wire logic branch_trap_flag,
	input wire logic step_cause,
	input wire logic branch_cause,
	input wire logic [31:0] timer_value,
	input wire logic timer_expired,
	input wire logic physical_address_extension,
	input wire logic [63:0] pdpte0,
	input wire logic [63:0] pdpte1,
	input wire logic [63:0] pdpte2,
	input wire logic [63:0] pdpte3,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [63:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [63:0] mem_rdata,
	output logic msr_req,
	output logic [31:0] msr_index,
	input wire logic msr_ack,
	input wire logic [63:0] msr_data,
	input wire logic msr_gp,
	input wire logic msr_smm_only,
	input wire logic msr_barred,
	output logic exit_done,
	output logic exit_abort,
	output logic busy
);
	typedef enum logic [3:0] {
		S_IDLE, S_ACT, S_INTR, S_PDBG, S_TMR, S_PDP,
		S_MRD, S_MSR, S_MWR, S_DONE, S_ABORT
	} vesms_state_e;

	vesms_state_e state;
	logic [2:0] ctrl;
	logic [31:0] gbase, mbase, mcount, idx, fail_idx;
	logic [2:0] fail_cause;
	logic done_st;
	logic [1:0] pdp_n;
	logic [63:0] msr_val;
	logic saved;
	logic [63:0] pdbg, op_data;
	logic [31:0] op_addr, intr_sv, ent_addr;
	logic op_we, keep, slt_pae;
	logic [63:0] pdp_sel;

	function automatic logic is_mem(input vesms_state_e s);
		return s inside {S_ACT, S_INTR, S_PDBG, S_TMR, S_PDP, S_MRD, S_MWR};
	endfunction

	assign slt_pae = ctrl[vesms_pkg::CTRL_SLT_EN] & physical_address_extension;
	assign ent_addr = mbase + idx * vesms_pkg::ENT_SIZE;
	assign keep = exit_init | exit_mce | exit_smi | exit_tpl | exit_veoi | exit_apicw
		| exit_mtf | (ss_load_block & ~exit_dbg); // [RQ4]

	always_comb begin
		pdbg = 64'h0;
		if (keep && just_entered) begin
			pdbg = entry_pdbg; // [RQ7]
		end else if (keep) begin
			pdbg[3:0] = bp_matched; // [RQ5] [RQ6]
			pdbg[vesms_pkg::PD_EBP] = enabled_bp_hit | (entry_pdbg[vesms_pkg::PD_EBP]
				& entry_pending_live); // [RQ8]
			// the stack-load case only ever reports the single-instruction cause
			if (ss_load_block & ~exit_dbg) begin
				pdbg[vesms_pkg::PD_BS] = single_step_flag & ~branch_trap_flag
					& step_cause; // [RQ10]
			end else begin
				pdbg[vesms_pkg::PD_BS] = single_step_flag & ((~branch_trap_flag & step_cause)
					| (branch_trap_flag & branch_cause)); // [RQ9]
			end
		end
		pdbg = pdbg & vesms_pkg::PD_MASK; // [RQ11]
	end

	always_comb begin
		intr_sv = intr_state;
		if (!exit_to_smm) begin
			intr_sv[vesms_pkg::INTR_SMI] = 1'b0; // [RQ2]
		end
		if (ctrl[vesms_pkg::CTRL_VNMI]) begin
			intr_sv[vesms_pkg::INTR_NMI] = vnmi_blocked; // [RQ3]
		end
	end

	always_comb begin
		case (pdp_n)
			2'h0: pdp_sel = pdpte0;
			2'h1: pdp_sel = pdpte1;
			2'h2: pdp_sel = pdpte2;
			default: pdp_sel = pdpte3;
		endcase
	end

	always_comb begin
		op_we = 1'b1;
		op_addr = gbase;
		op_data = 64'h0;
		case (state)
			S_ACT: begin
				op_addr = gbase + vesms_pkg::G_ACT;
				op_data = {32'h0, activity_state}; // [RQ1]
			end
			S_INTR: begin
				op_addr = gbase + vesms_pkg::G_INTR;
				op_data = {32'h0, intr_sv};
			end
			S_PDBG: begin
				op_addr = gbase + vesms_pkg::G_PDBG;
				op_data = pdbg;
			end
			S_TMR: begin
				op_addr = gbase + vesms_pkg::G_TMR;
				op_data = {32'h0, timer_expired ? 32'h0 : timer_value}; // [RQ12]
			end
			S_PDP: begin
				op_addr = gbase + vesms_pkg::G_PDP + {27'h0, pdp_n, 3'h0};
				// undefined bits 11:9 are written as zero
				op_data = pdp_sel & ~vesms_pkg::PDP_UNDEF; // [RQ13]
			end
			S_MRD: begin
				op_we = 1'b0;
				op_addr = ent_addr;
			end
			S_MWR: begin
				op_addr = ent_addr + vesms_pkg::ENT_DATA;
				op_data = msr_val; // [RQ16]
			end
			default: begin
				op_we = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0;
			mem_wdata <= 64'h0;
		end else if (is_mem(state) && !mem_ack) begin
			mem_req <= 1'b1;
			mem_we <= op_we;
			mem_addr <= op_addr;
			mem_wdata <= op_data;
		end else begin
			mem_req <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= S_IDLE;
			idx <= 32'h0;
			pdp_n <= 2'h0;
			saved <= 1'b0;
			msr_val <= 64'h0;
			msr_req <= 1'b0;
			msr_index <= 32'h0;
			fail_cause <= vesms_pkg::F_NONE;
			fail_idx <= 32'h0;
		end else begin
			case (state)
				S_IDLE: begin
					if (exit_start) begin
						state <= S_ACT;
						idx <= 32'h0;
						pdp_n <= 2'h0;
						saved <= 1'b0;
						fail_cause <= vesms_pkg::F_NONE;
					end
				end
				S_ACT: if (mem_ack) state <= S_INTR;
				S_INTR: if (mem_ack) state <= S_PDBG;
				S_PDBG: begin
					if (mem_ack) begin
						if (ctrl[vesms_pkg::CTRL_SAVE_TMR]) begin
							state <= S_TMR;
						end else if (slt_pae) begin
							state <= S_PDP;
						end else begin
							saved <= 1'b1; // [RQ14]
							state <= mcount == 32'h0 ? S_DONE : S_MRD;
						end
					end
				end
				S_TMR: begin
					if (mem_ack) begin
						if (slt_pae) begin
							state <= S_PDP;
						end else begin
							saved <= 1'b1;
							state <= mcount == 32'h0 ? S_DONE : S_MRD;
						end
					end
				end
				S_PDP: begin
					if (mem_ack) begin
						pdp_n <= pdp_n + 2'h1;
						if (pdp_n == 2'h3) begin
							saved <= 1'b1; // [RQ15]
							state <= mcount == 32'h0 ? S_DONE : S_MRD;
						end
					end
				end
				S_MRD: begin
					if (mem_ack) begin
						msr_index <= mem_rdata[31:0];
						if (mem_rdata[31:8] == vesms_pkg::APIC_RANGE) begin
							fail_cause <= vesms_pkg::F_APIC; // [RQ17]
							state <= S_ABORT;
						end else if (mem_rdata[63:32] != 32'h0) begin
							fail_cause <= vesms_pkg::F_HIGH; // [RQ20]
							state <= S_ABORT;
						end else begin
							msr_req <= 1'b1;
							state <= S_MSR;
						end
					end
				end
				S_MSR: begin
					if (msr_ack) begin
						msr_req <= 1'b0;
						msr_val <= msr_data;
						state <= S_ABORT;
						if (msr_gp) begin
							fail_cause <= vesms_pkg::F_GP; // [RQ21]
						end else if (msr_smm_only && !exit_to_smm) begin
							fail_cause <= vesms_pkg::F_SMM; // [RQ18]
						end else if (msr_barred) begin
							fail_cause <= vesms_pkg::F_MODEL; // [RQ19]
						end else begin
							state <= S_MWR;
						end
					end
				end
				S_MWR: begin
					if (mem_ack) begin
						idx <= idx + 32'h1;
						state <= idx + 32'h1 == mcount ? S_DONE : S_MRD; // [RQ16]
					end
				end
				S_ABORT: begin
					fail_idx <= idx;
					state <= S_IDLE; // [RQ23]
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// done means host loading may go on; an abort never produces it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exit_done <= 1'b0;
			exit_abort <= 1'b0;
			busy <= 1'b0;
			done_st <= 1'b0;
		end else begin
			exit_done <= state == S_DONE; // [RQ23]
			busy <= state != S_IDLE && state != S_DONE && state != S_ABORT;
			if (state == S_ABORT) begin
				exit_abort <= 1'b1; // [RQ22]
			end else if (state == S_IDLE && exit_start) begin
				exit_abort <= 1'b0;
			end
			if (state == S_DONE) begin
				done_st <= 1'b1;
			end else if (state == S_IDLE && exit_start) begin
				done_st <= 1'b0;
			end
		end
	end

	// axi4-lite write side: address and data taken in either order
	logic aw_got, w_got;
	logic [AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= vesms_pkg::RESP_OK;
			ctrl <= vesms_pkg::CTRL_RST;
			gbase <= 32'h0;
			mbase <= 32'h0;
			mcount <= 32'h0;
		end else begin
			s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
			s_axi_wready <= !w_got && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_got && w_got) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= vesms_pkg::RESP_OK;
				// setup registers are frozen while busy, from the second cycle of an exit on
				if (AW'(vesms_pkg::REG_CTRL) == aw_addr) begin
					if (!busy && w_strb[0]) ctrl <= w_data[2:0];
				end else if (AW'(vesms_pkg::REG_GBASE) == aw_addr) begin
					if (!busy) gbase <= w_data;
				end else if (AW'(vesms_pkg::REG_MBASE) == aw_addr) begin
					if (!busy) mbase <= w_data;
				end else if (AW'(vesms_pkg::REG_MCOUNT) == aw_addr) begin
					if (!busy) mcount <= w_data;
				end else if (AW'(vesms_pkg::REG_STATUS) != aw_addr
					&& AW'(vesms_pkg::REG_FAILIDX) != aw_addr) begin
					s_axi_bresp <= vesms_pkg::RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= vesms_pkg::RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= vesms_pkg::RESP_OK;
				s_axi_rdata <= 32'h0;
				if (AW'(vesms_pkg::REG_CTRL) == s_axi_araddr) begin
					s_axi_rdata <= {29'h0, ctrl};
				end else if (AW'(vesms_pkg::REG_GBASE) == s_axi_araddr) begin
					s_axi_rdata <= gbase;
				end else if (AW'(vesms_pkg::REG_MBASE) == s_axi_araddr) begin
					s_axi_rdata <= mbase;
				end else if (AW'(vesms_pkg::REG_MCOUNT) == s_axi_araddr) begin
					s_axi_rdata <= mcount;
				end else if (AW'(vesms_pkg::REG_STATUS) == s_axi_araddr) begin
					s_axi_rdata <= {25'h0, fail_cause, 1'b0, exit_abort, done_st, busy};
				end else if (AW'(vesms_pkg::REG_FAILIDX) == s_axi_araddr) begin
					s_axi_rdata <= fail_idx;
				end else begin
					s_axi_rresp <= vesms_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence seq_ent_back;
		state == S_MRD && mem_ack;
	endsequence
	sequence seq_to_abort;
		##1 state == S_ABORT ##1 state == S_IDLE ##1 exit_abort;
	endsequence

	chk_smi_clear: assert property (state == S_INTR && mem_req && !exit_to_smm
		|-> !mem_wdata[vesms_pkg::INTR_SMI]) else $error("smi bit saved set"); // [RQ2]
	chk_vnmi_bit: assert property (state == S_INTR && mem_req && ctrl[vesms_pkg::CTRL_VNMI]
		|-> mem_wdata[vesms_pkg::INTR_NMI] == vnmi_blocked)
		else $error("nmi bit not virtual"); // [RQ3]
	chk_pdbg_zero: assert property (state == S_PDBG && mem_req && !keep
		|-> mem_wdata == 64'h0) else $error("pending debug not clear"); // [RQ4]
	chk_pdbg_resv: assert property (state == S_PDBG && mem_req
		|-> (mem_wdata & ~vesms_pkg::PD_MASK) == 64'h0) else $error("reserved bit set"); // [RQ11]
	chk_bs_clear: assert property (state == S_PDBG && mem_req && !single_step_flag
		&& !just_entered |-> !mem_wdata[vesms_pkg::PD_BS]) else $error("bs set"); // [RQ9]
	chk_timer_skip: assert property (state == S_TMR
		|-> ctrl[vesms_pkg::CTRL_SAVE_TMR]) else $error("timer saved unasked"); // [RQ12]
	chk_store_order: assert property (msr_req |-> saved)
		else $error("msr store before guest save"); // [RQ15]
	chk_apic_fail: assert property (seq_ent_back and mem_rdata[31:8] == vesms_pkg::APIC_RANGE
		|-> seq_to_abort) else $error("apic entry not failed"); // [RQ17]
	chk_high_fail: assert property (seq_ent_back and mem_rdata[63:32] != 32'h0
		|-> seq_to_abort) else $error("high bits entry not failed"); // [RQ20]
	chk_gp_fail: assert property (state == S_MSR && msr_ack && msr_gp
		|=> state == S_ABORT ##1 state == S_IDLE) else $error("gp read not failed"); // [RQ21]
	chk_abort_nodone: assert property (state == S_ABORT
		|=> !exit_done [*3]) else $error("done after abort"); // [RQ23]
endmodule

// ### tb/vesms_mem_model.sv
`timescale 1ns/100ps
module vesms_mem_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	output logic mem_ack,
	output logic [63:0] mem_rdata,
	input wire logic msr_req,
	input wire logic [31:0] msr_index,
	output logic msr_ack,
	output logic [63:0] msr_data,
	output logic msr_gp,
	output logic msr_smm_only,
	output logic msr_barred
);
	logic [63:0] mem [logic [31:0]];
	int wait_n;
	function automatic logic [63:0] msr_val(input logic [31:0] idx);
		return {idx ^ 32'h5a5a_5a5a, ~idx};
	endfunction
	// idle answer lines toggle so a late sample never sees stale data
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{mem_ack, msr_ack, msr_gp, msr_smm_only, msr_barred} <= '0;
			{mem_rdata, msr_data} <= '0;
			wait_n <= 0;
		end else begin
			mem_ack <= 1'b0;
			msr_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			{msr_data, msr_gp, msr_smm_only, msr_barred} <= ~{msr_data, msr_gp, msr_smm_only, msr_barred};
			if ((mem_req && !mem_ack) || (msr_req && !msr_ack)) begin
				if (wait_n != 0) begin
					wait_n <= wait_n - 1;
				end else if (mem_req && !mem_ack) begin
					wait_n <= $urandom_range(3);
					mem_ack <= 1'b1;
					if (mem_we)
						mem[mem_addr] = mem_wdata;
					else
						mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
				end else begin
					wait_n <= $urandom_range(3);
					msr_ack <= 1'b1;
					msr_data <= msr_val(msr_index);
					msr_gp <= (msr_index[31:28] == 4'h9);
					msr_smm_only <= (msr_index[31:28] == 4'ha);
					msr_barred <= (msr_index[31:28] == 4'hb);
				end
			end
		end
	end
endmodule

// ### tb/vesms_top_tb.sv
`timescale 1ns/100ps
module vesms_top_tb;
	logic clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, activity_state, intr_state, timer_value;
	logic [31:0] mem_addr, msr_index;
	logic [3:0] s_axi_wstrb, bp_matched;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic exit_start, exit_to_smm, vnmi_blocked, exit_init, exit_mce, exit_smi, exit_tpl;
	logic exit_veoi, exit_apicw, exit_mtf, exit_dbg, ss_load_block, just_entered;
	logic enabled_bp_hit, entry_pending_live, single_step_flag, branch_trap_flag;
	logic step_cause, branch_cause, timer_expired, physical_address_extension;
	logic [63:0] entry_pdbg, pdpte0, pdpte1, pdpte2, pdpte3, mem_wdata, mem_rdata, msr_data;
	logic mem_req, mem_we, mem_ack, msr_req, msr_ack, msr_gp, msr_smm_only, msr_barred;
	logic exit_done, exit_abort, busy;
	logic [8:0] kd;
	logic [2:0] ctrl;
	logic [159:0] e;
	logic [33:0] r;
	logic [159:0] exp_q[$];
	logic [33:0] rd_q[$];
	int n_fail, comparisons, cyc;
	logic [8:0] kt [10] = '{9'h000, 9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040,
		9'h100, 9'h180};
	logic [63:0] bt [6] = '{64'h0, 64'h830, 64'ha000_0001, 64'hb000_0002, 64'h1_0000_0c00,
		64'h9000_0003};
	localparam logic [31:0] GB = 32'h1000;
	localparam logic [31:0] MB = 32'h2000;
	assign s_axi_wstrb = 4'hf;
	assign {ss_load_block, exit_dbg, exit_mtf, exit_apicw, exit_veoi, exit_tpl, exit_smi, exit_mce,
		exit_init} = kd;

	vesms_top vesms_top_i (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .exit_start, .exit_to_smm, .activity_state, .intr_state,
		.vnmi_blocked, .exit_init, .exit_mce, .exit_smi, .exit_tpl, .exit_veoi, .exit_apicw,
		.exit_mtf, .exit_dbg, .ss_load_block, .just_entered, .entry_pdbg, .bp_matched,
		.enabled_bp_hit, .entry_pending_live, .single_step_flag, .branch_trap_flag, .step_cause,
		.branch_cause, .timer_value, .timer_expired, .physical_address_extension, .pdpte0,
		.pdpte1, .pdpte2, .pdpte3, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
		.msr_req, .msr_index, .msr_ack, .msr_data, .msr_gp, .msr_smm_only, .msr_barred,
		.exit_done, .exit_abort, .busy);
	vesms_mem_model vesms_mem_model_i (.clk, .arst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata, .msr_req, .msr_index, .msr_ack, .msr_data, .msr_gp, .msr_smm_only,
		.msr_barred);

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] want);
		comparisons++;
		if (got !== want) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic ex(input logic [31:0] a, input logic [63:0] d, input logic [63:0] m);
		exp_q.push_back({a, m, d & m});
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check(64'(s_axi_bresp), 64'(er));
	endtask
	task automatic axr(input logic [7:0] a, input logic [33:0] er);
		rd_q.push_back(er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// k exit kind bits (none, one, or ss_load_block with exit_dbg), n entries, last entry replaced by bad when ab
	task automatic run_exit(input logic [8:0] k, input int n, input logic [63:0] bad,
		input logic ab);
		logic [63:0] pd, m;
		logic [31:0] it;
		ctrl = 3'($urandom);
		kd <= k;
		just_entered <= ($urandom_range(3) == 0);
		exit_to_smm <= ab ? 1'b0 : 1'($urandom);
		{vnmi_blocked, enabled_bp_hit, entry_pending_live, single_step_flag} <= 4'($urandom);
		{branch_trap_flag, step_cause, branch_cause, timer_expired} <= 4'($urandom);
		physical_address_extension <= 1'($urandom);
		{activity_state, intr_state, timer_value} <= {$urandom, $urandom, $urandom};
		bp_matched <= 4'($urandom);
		entry_pdbg <= {$urandom, $urandom};
		{pdpte0, pdpte1} <= {$urandom, $urandom | 1, $urandom, $urandom | 1};
		{pdpte2, pdpte3} <= {$urandom, $urandom | 1, $urandom, $urandom | 1};
		for (int i = 0; i < n; i++)
			vesms_mem_model_i.mem[MB + 32'(16 * i)] = (ab && i == n - 1) ? bad : 64'(32'hc80 + i);
		axw(vesms_pkg::REG_CTRL, 32'(ctrl), vesms_pkg::RESP_OK);
		axw(vesms_pkg::REG_GBASE, GB, vesms_pkg::RESP_OK);
		axw(vesms_pkg::REG_MBASE, MB, vesms_pkg::RESP_OK);
		axw(vesms_pkg::REG_MCOUNT, 32'(n), vesms_pkg::RESP_OK);
		ex(GB + vesms_pkg::G_ACT, 64'(activity_state), '1);
		it = intr_state;
		if (!exit_to_smm)
			it[vesms_pkg::INTR_SMI] = 1'b0;
		if (ctrl[0])
			it[vesms_pkg::INTR_NMI] = vnmi_blocked;
		ex(GB + vesms_pkg::G_INTR, 64'(it), '1);
		pd = '0;
		m = '1;
		// for the listed exit kinds, breakpoint match bits are optional, so they are left out of the compare unless just_entered
		if (|k[6:0] || k == 9'h100) begin
			pd[12] = enabled_bp_hit | (entry_pdbg[12] & entry_pending_live);
			pd[14] = single_step_flag & (branch_trap_flag ? branch_cause & !k[8] : step_cause);
			m = ~64'hf;
			if (just_entered) begin
				pd = entry_pdbg & vesms_pkg::PD_MASK;
				m = '1;
			end
		end
		ex(GB + vesms_pkg::G_PDBG, pd, m);
		if (ctrl[1])
			ex(GB + vesms_pkg::G_TMR, timer_expired ? 64'h0 : 64'(timer_value), '1);
		if (ctrl[2] && physical_address_extension) begin
			ex(GB + vesms_pkg::G_PDP, pdpte0, ~vesms_pkg::PDP_UNDEF);
			ex(GB + vesms_pkg::G_PDP + 8, pdpte1, ~vesms_pkg::PDP_UNDEF);
			ex(GB + vesms_pkg::G_PDP + 16, pdpte2, ~vesms_pkg::PDP_UNDEF);
			ex(GB + vesms_pkg::G_PDP + 24, pdpte3, ~vesms_pkg::PDP_UNDEF);
		end
		for (int i = 0; i < n - 32'(ab); i++)
			ex(MB + 32'(16 * i + 8), vesms_mem_model_i.msr_val(32'hc80 + i), '1);
		exit_start <= 1'b1;
		@(posedge clk);
		exit_start <= 1'b0;
		do @(posedge clk); while (exit_done !== 1'b1 && exit_abort !== 1'b1);
		check(64'({exit_done, exit_abort}), 64'({!ab, ab}));
		repeat (12) @(posedge clk);
		check(64'(exp_q.size()), 64'h0);
		check(64'(busy), 64'h0);
	endtask

	// every design memory write is matched in order against the oldest note
	always @(posedge clk) begin
		if (mem_req && mem_we && mem_ack) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
			check(64'(mem_addr), 64'(e[159:128]));
			check(mem_wdata & e[127:64], e[63:0]);
			check(64'(busy), 64'h1);
		end
		if (s_axi_rvalid && s_axi_rready) begin
			r = rd_q.pop_front();
			check(64'({s_axi_rresp, s_axi_rdata}), 64'(r));
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		void'($urandom(32'h98b8));
		arst_n = 1'b0;
		{exit_start, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{kd, just_entered, exit_to_smm, vnmi_blocked, enabled_bp_hit, entry_pending_live} = '0;
		{single_step_flag, branch_trap_flag, step_cause, branch_cause, timer_expired} = '0;
		{physical_address_extension, activity_state, intr_state, timer_value, bp_matched} = '0;
		{entry_pdbg, pdpte0, pdpte1, pdpte2, pdpte3} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		axr(vesms_pkg::REG_STATUS, 34'h0);
		axr(8'h40, {vesms_pkg::RESP_SLVERR, 32'h0});
		axw(8'h40, 32'h1, vesms_pkg::RESP_SLVERR);
		// each failing cause stops the walk at entry 1
		for (int c = 1; c < 6; c++) begin
			run_exit(kt[c], 2, bt[c], 1'b1);
			axr(vesms_pkg::REG_STATUS, {27'h0, 3'(c), 4'h4});
			axr(vesms_pkg::REG_FAILIDX, 34'h1);
		end
		for (int j = 0; j < 10; j++)
			run_exit(kt[j], j % 4, 64'h0, 1'b0);
		print_verdict();
	end
endmodule
